// ===== bsw_top.sv
// battery switchover selector with latched power event flags
// assumes comparator and adc inputs come from analog, asynchronous
// Summary of operation
// - switchover active after reset; config bit 1 pins supply to main
// - peripheral config bit 6 reads 1 on main, 0 on battery
// - source select 01: low supervisory comparator moves supply to battery
// - source select 00: low main supply comparator moves to battery
// - pin function 01x enables falling edge of control pin switching
// - return to main needs all enabled restore conditions, main good
// - supervisory source selected: return also needs supervisory input good
// - control pin enabled: return also needs the pin high
// - shared interrupt off after reset; enabled by bit 1 of ie2
// - flags latched until software writes flag register; enables select
// - switchover flag bit 1 sets on main to battery change
// - restore flag bit 7 sets on battery to main change
// - these flags set regardless of enables; cleared by writing 0
// - adc flag sets when supervisory value moves beyond delta
// - periodic background conversions plus software start register
// - cell flag sets below threshold or on new battery result
// - comparator flag sets while supervisory input below threshold
// - switching supply never stops clock or logic state
// - metering adc reported unavailable and disabled on battery
`timescale 1ns/10ps
module bsw_top (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       main_supply_low,
    input  wire logic       supervisory_low,
    input  wire logic       battery_control_pin,
    input  wire logic       cell_adc_done,
    input  wire logic [7:0] cell_adc_result,
    input  wire logic       supervisory_adc_done,
    input  wire logic [7:0] supervisory_adc_result,
    output logic            supervisory_adc_start,
    output logic            switched_supply_source,
    output logic            metering_adc_enable,
    output logic            power_event_irq
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] next_sync_a;
    logic       main_low_s;
    logic       sup_low_s;
    logic       pin_s;
    logic       cell_done_s;
    logic       sup_done_s;
    logic       pin_prev;
    logic       cell_done_prev;
    logic       sup_done_prev;

    always_comb begin
        next_sync_a = {supervisory_adc_done, cell_adc_done,
                       battery_control_pin, supervisory_low,
                       main_supply_low};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a <= 5'h04;
            sync_b <= 5'h04;
            pin_prev <= 1'b1;
            cell_done_prev <= 1'b0;
            sup_done_prev <= 1'b0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= sync_a;
            pin_prev <= sync_b[2];
            cell_done_prev <= sync_b[3];
            sup_done_prev <= sync_b[4];
        end
    end

    assign main_low_s  = sync_b[0];
    assign sup_low_s   = sync_b[1];
    assign pin_s       = sync_b[2];
    assign cell_done_s = sync_b[3];
    assign sup_done_s  = sync_b[4];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ie2;
    logic [7:0] ev_en;
    logic [7:0] delta_th;
    logic [7:0] peripheral_configuration;
    logic [7:0] sw_cfg;
    logic [7:0] ev_flag;
    logic [7:0] bat_th;
    logic [7:0] pin_cfg;
    logic [7:0] cell_val;
    logic [7:0] sup_val;
    logic [7:0] next_ie2;
    logic [7:0] next_ev_en;
    logic [7:0] next_delta_th;
    logic [7:0] next_peripheral_configuration;
    logic [7:0] next_sw_cfg;
    logic [7:0] next_ev_flag;
    logic [7:0] next_bat_th;
    logic [7:0] next_pin_cfg;
    logic [7:0] next_cell_val;
    logic [7:0] next_sup_val;
    logic [7:0] ev_set;

    // ------------------------------------------------------------
    // switchover state machine
    // ------------------------------------------------------------
    bsw_pkg::bsw_state_t state;
    bsw_pkg::bsw_state_t next_state;
    logic pin_enabled;
    logic pin_fall;
    logic go_battery;
    logic restore_ok;

    assign pin_enabled = (pin_cfg[2:1] == bsw_pkg::PIN_FN_BATTERY_CONTROL_PIN);
    assign pin_fall = pin_enabled && pin_prev && !pin_s;

    always_comb begin
        go_battery = pin_fall;
        if (sw_cfg[1:0] == bsw_pkg::SRC_SUPERVISORY) begin
            go_battery = go_battery || sup_low_s;
        end else if (sw_cfg[1:0] == bsw_pkg::SRC_SUPPLY) begin
            go_battery = go_battery || main_low_s;
        end
        restore_ok = !main_low_s;
        if (sw_cfg[1:0] == bsw_pkg::SRC_SUPERVISORY) begin
            restore_ok = restore_ok && !sup_low_s;
        end
        if (pin_enabled) begin
            restore_ok = restore_ok && pin_s;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            bsw_pkg::BSW_ON_MAIN: begin
                // config bit 1 holds the supply on main
                if (!sw_cfg[bsw_pkg::SW_DISABLE_BIT] && go_battery) begin
                    next_state = bsw_pkg::BSW_ON_BATTERY;
                end
            end
            bsw_pkg::BSW_ON_BATTERY: begin
                if (sw_cfg[bsw_pkg::SW_DISABLE_BIT] ||
                    (restore_ok && !go_battery)) begin
                    next_state = bsw_pkg::BSW_ON_MAIN;
                end
            end
            default: next_state = bsw_pkg::BSW_ON_MAIN;
        endcase
    end

    // only the source bit changes; clock and other state keep running
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= bsw_pkg::BSW_ON_MAIN;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // background conversion timer
    // ------------------------------------------------------------
    logic [12:0] adc_cnt;
    logic [12:0] next_adc_cnt;
    logic        next_adc_start;
    logic        sw_start;

    assign sw_start = sfr_wr && (sfr_addr == bsw_pkg::ADDR_ADC_GO);

    always_comb begin
        next_adc_start = 1'b0;
        if (adc_cnt == 13'(bsw_pkg::ADC_PERIOD_CYC - 1)) begin
            next_adc_cnt = 13'h0000;
            next_adc_start = 1'b1;
        end else begin
            next_adc_cnt = adc_cnt + 13'h0001;
        end
        if (sw_start) begin
            next_adc_start = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adc_cnt <= 13'h0000;
            supervisory_adc_start <= 1'b0;
        end else begin
            adc_cnt <= next_adc_cnt;
            supervisory_adc_start <= next_adc_start;
        end
    end

    // ------------------------------------------------------------
    // event detection and register writes
    // ------------------------------------------------------------
    logic       sup_new;
    logic       cell_new;
    logic [7:0] sup_diff;

    assign sup_new = sup_done_s && !sup_done_prev;
    assign cell_new = cell_done_s && !cell_done_prev;
    assign sup_diff = (supervisory_adc_result > sup_val) ?
                      supervisory_adc_result - sup_val :
                      sup_val - supervisory_adc_result;

    always_comb begin
        ev_set = 8'h00;
        ev_set[bsw_pkg::F_COMP_BIT] = sup_low_s;
        ev_set[bsw_pkg::F_SWITCH_BIT] =
            (state == bsw_pkg::BSW_ON_MAIN) &&
            (next_state == bsw_pkg::BSW_ON_BATTERY);
        ev_set[bsw_pkg::F_RESTORE_BIT] =
            (state == bsw_pkg::BSW_ON_BATTERY) &&
            (next_state == bsw_pkg::BSW_ON_MAIN);
        ev_set[bsw_pkg::F_CELL_BIT] = cell_new;
        ev_set[bsw_pkg::F_ADC_BIT] = sup_new && (sup_diff > delta_th);
    end

    always_comb begin
        next_ie2 = ie2;
        next_ev_en = ev_en;
        next_delta_th = delta_th;
        next_sw_cfg = sw_cfg;
        next_bat_th = bat_th;
        next_pin_cfg = pin_cfg;
        next_peripheral_configuration = peripheral_configuration;
        next_ev_flag = ev_flag;
        next_cell_val = cell_new ? cell_adc_result : cell_val;
        next_sup_val = sup_new ? supervisory_adc_result : sup_val;
        if (sfr_wr) begin
            if (sfr_addr == bsw_pkg::ADDR_IEIP) begin
                next_ie2 = sfr_wdata;
            end else if (sfr_addr == bsw_pkg::ADDR_EV_EN) begin
                next_ev_en = sfr_wdata;
            end else if (sfr_addr == bsw_pkg::ADDR_DELTA) begin
                next_delta_th = sfr_wdata;
            end else if (sfr_addr == bsw_pkg::ADDR_PERIPHERAL_CONFIGURATION) begin
                next_peripheral_configuration = sfr_wdata;
            end else if (sfr_addr == bsw_pkg::ADDR_SW_CFG) begin
                next_sw_cfg = sfr_wdata;
            end else if (sfr_addr == bsw_pkg::ADDR_BAT_TH) begin
                next_bat_th = sfr_wdata;
            end else if (sfr_addr == bsw_pkg::ADDR_PIN_CFG) begin
                next_pin_cfg = sfr_wdata;
            end else if (sfr_addr == bsw_pkg::ADDR_EV_FLAG) begin
                next_ev_flag = ev_flag & sfr_wdata;
            end
        end
        if (cell_new && (cell_adc_result < bat_th)) begin
            next_ev_flag[bsw_pkg::F_CELL_BIT] = 1'b1;
        end
        next_ev_flag = next_ev_flag | ev_set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ie2 <= bsw_pkg::RST_ZERO;
            ev_en <= bsw_pkg::RST_ZERO;
            delta_th <= bsw_pkg::RST_DELTA;
            peripheral_configuration <= bsw_pkg::RST_ZERO;
            sw_cfg <= bsw_pkg::RST_ZERO;
            ev_flag <= bsw_pkg::RST_ZERO;
            bat_th <= bsw_pkg::RST_BAT_TH;
            pin_cfg <= bsw_pkg::RST_ZERO;
            cell_val <= bsw_pkg::RST_ZERO;
            sup_val <= bsw_pkg::RST_ZERO;
        end else begin
            ie2 <= next_ie2;
            ev_en <= next_ev_en;
            delta_th <= next_delta_th;
            peripheral_configuration <= next_peripheral_configuration;
            sw_cfg <= next_sw_cfg;
            ev_flag <= next_ev_flag;
            bat_th <= next_bat_th;
            pin_cfg <= next_pin_cfg;
            cell_val <= next_cell_val;
            sup_val <= next_sup_val;
        end
    end

    // ------------------------------------------------------------
    // outputs and read mux
    // ------------------------------------------------------------
    logic on_main;
    assign on_main = (state == bsw_pkg::BSW_ON_MAIN);

    always_ff @(posedge clk) begin
        if (rst) begin
            switched_supply_source <= 1'b1;
            metering_adc_enable <= 1'b1;
            power_event_irq <= 1'b0;
        end else begin
            switched_supply_source <= (next_state == bsw_pkg::BSW_ON_MAIN);
            metering_adc_enable <=
                (next_state == bsw_pkg::BSW_ON_MAIN);
            power_event_irq <= next_ie2[bsw_pkg::MASTER_EN_BIT] &&
                               |(next_ev_flag & next_ev_en);
        end
    end

    always_comb begin
        sfr_rdata = 8'h00;
        if (!sfr_rd) begin
            sfr_rdata = 8'h00;
        end else if (sfr_addr == bsw_pkg::ADDR_IEIP) begin
            sfr_rdata = ie2;
        end else if (sfr_addr == bsw_pkg::ADDR_BAT_ADC) begin
            sfr_rdata = cell_val;
        end else if (sfr_addr == bsw_pkg::ADDR_EV_EN) begin
            sfr_rdata = ev_en;
        end else if (sfr_addr == bsw_pkg::ADDR_DELTA) begin
            sfr_rdata = delta_th;
        end else if (sfr_addr == bsw_pkg::ADDR_PERIPHERAL_CONFIGURATION) begin
            sfr_rdata = {peripheral_configuration[7], on_main, peripheral_configuration[5:0]};
        end else if (sfr_addr == bsw_pkg::ADDR_SW_CFG) begin
            sfr_rdata = sw_cfg;
        end else if (sfr_addr == bsw_pkg::ADDR_EV_FLAG) begin
            sfr_rdata = ev_flag;
        end else if (sfr_addr == bsw_pkg::ADDR_BAT_TH) begin
            sfr_rdata = bat_th;
        end else if (sfr_addr == bsw_pkg::ADDR_PIN_CFG) begin
            sfr_rdata = pin_cfg;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_HOLD_MAIN: assert property (@(posedge clk) disable iff (rst)
        sw_cfg[1] |=> state == bsw_pkg::BSW_ON_MAIN)
        else $error("supply left main while switchover disabled");
    AST_SRC_PIN: assert property (@(posedge clk) disable iff (rst)
        switched_supply_source == on_main)
        else $error("source output disagrees with state");
    AST_SUP_SWITCH: assert property (@(posedge clk) disable iff (rst)
        on_main && !sw_cfg[1] && sw_cfg[1:0] == 2'h1 && sup_low_s
        |=> !on_main)
        else $error("no switch on low supervisory input");
    AST_MAIN_SWITCH: assert property (@(posedge clk) disable iff (rst)
        on_main && sw_cfg[1:0] == 2'h0 && main_low_s |=> !on_main)
        else $error("no switch on low main supply");
    AST_NO_EARLY_RESTORE: assert property (@(posedge clk)
        disable iff (rst)
        !on_main && !sw_cfg[1] && main_low_s |=> !on_main)
        else $error("restored while main supply low");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst)
        power_event_irq == (ie2[1] && |(ev_flag & ev_en)))
        else $error("interrupt does not match flags");
    AST_SW_FLAG: assert property (@(posedge clk) disable iff (rst)
        $fell(on_main) |-> ev_flag[1])
        else $error("switchover flag not set");
    AST_RESTORE_FLAG: assert property (@(posedge clk)
        disable iff (rst)
        $rose(on_main) |-> ev_flag[7])
        else $error("restore flag not set");
    AST_METER_OFF: assert property (@(posedge clk) disable iff (rst)
        !on_main |-> !metering_adc_enable)
        else $error("metering enabled on battery");
    AST_PIN_SWITCH: assert property (@(posedge clk) disable iff (rst)
        on_main && !sw_cfg[1] && pin_fall |=> !on_main)
        else $error("no switch on control pin fall");
    AST_FLAG_KEEP: assert property (@(posedge clk) disable iff (rst)
        !(sfr_wr && sfr_addr == bsw_pkg::ADDR_EV_FLAG)
        |=> (ev_flag & $past(ev_flag)) == $past(ev_flag))
        else $error("flag dropped without a clear write");
endmodule

// ===== bsw_pkg.sv
// package for the battery switchover and power event block
// assumes an 8-bit special function register port from the core
package bsw_pkg;
    // register addresses
    localparam logic [7:0] ADDR_IEIP = 8'ha9;
    localparam logic [7:0] ADDR_ADC_GO = 8'hd8;
    localparam logic [7:0] ADDR_BAT_ADC = 8'hdf;
    localparam logic [7:0] ADDR_EV_EN = 8'hec;
    localparam logic [7:0] ADDR_DELTA = 8'hf3;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIGURATION = 8'hf4;
    localparam logic [7:0] ADDR_SW_CFG = 8'hf5;
    localparam logic [7:0] ADDR_EV_FLAG = 8'hf8;
    localparam logic [7:0] ADDR_BAT_TH = 8'hfa;
    localparam logic [7:0] ADDR_PIN_CFG = 8'hff;
    // field positions
    localparam int MASTER_EN_BIT = 1;
    localparam int SW_DISABLE_BIT = 1;
    localparam int SOURCE_BIT = 6;
    localparam int F_COMP_BIT = 0;
    localparam int F_SWITCH_BIT = 1;
    localparam int F_CELL_BIT = 2;
    localparam int F_ADC_BIT = 3;
    localparam int F_RESTORE_BIT = 7;
    localparam logic [1:0] SRC_SUPPLY = 2'h0;
    localparam logic [1:0] SRC_SUPERVISORY = 2'h1;
    localparam logic [1:0] PIN_FN_BATTERY_CONTROL_PIN = 2'h1;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_BAT_TH = 8'h00;
    localparam logic [7:0] RST_DELTA = 8'h00;
    // background conversion interval in cycles
    localparam int ADC_PERIOD_CYC = 4096;
    localparam logic [1:0] STATE_MAIN = 2'b00;
    typedef enum logic [1:0] {
        BSW_ON_MAIN    = 2'b00,
        BSW_ON_BATTERY = 2'b01
    } bsw_state_t;
endpackage

// ===== bsw_partner.sv
// far-side model: supply comparators, control pin and both adcs
// assumes its outputs are changed 1ns after the rising edge of clk
`timescale 1ns/10ps
module bsw_partner (
    input  wire logic       clk,
    input  wire logic       supervisory_adc_start,
    output logic            main_supply_low,
    output logic            supervisory_low,
    output logic            battery_control_pin,
    output logic            cell_adc_done,
    output logic      [7:0] cell_adc_result,
    output logic            supervisory_adc_done,
    output logic      [7:0] supervisory_adc_result
);
    logic [7:0] sup_level;
    int         start_cnt;

    initial begin
        main_supply_low = 1'b0;
        supervisory_low = 1'b0;
        battery_control_pin = 1'b1;
        cell_adc_done = 1'b0;
        cell_adc_result = 8'h00;
        supervisory_adc_done = 1'b0;
        supervisory_adc_result = 8'h00;
        sup_level = 8'h00;
        start_cnt = 0;
    end

    // ------------------------------------------------
    // supervisory conversion, result held until the next
    // ------------------------------------------------
    always @(posedge clk) begin
        if (supervisory_adc_start === 1'b1) begin
            start_cnt = start_cnt + 1;
            repeat (3) @(posedge clk);
            #1 supervisory_adc_result = sup_level;
            @(posedge clk);
            #1 supervisory_adc_done = 1'b1;
            @(posedge clk);
            #1 supervisory_adc_done = 1'b0;
        end
    end

    // ------------------------------------------------
    // one battery conversion with the given result
    // ------------------------------------------------
    task automatic cell_conv(input logic [7:0] val);
        @(posedge clk);
        #1 cell_adc_result = val;
        @(posedge clk);
        #1 cell_adc_done = 1'b1;
        @(posedge clk);
        #1 cell_adc_done = 1'b0;
    endtask
endmodule

// ===== test_bsw_top.sv
// testbench for the battery switchover and power event block
// assumes bsw_pkg, bsw_top and bsw_partner are compiled first
`timescale 1ns/10ps
module test_bsw_top;
    logic       clk, rst, sfr_wr, sfr_rd, mlow, slow, pin;
    logic       cdone, sdone, sstart, src, men, irq, last_src;
    logic [7:0] addr, wdata, rdata, cres, sres, v;
    logic [7:0] rd_q[$];
    logic       src_q[$];
    int         error_cnt, samples_checked, seed, n0, i;

    bsw_top DUT (
        .clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(addr), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .main_supply_low(mlow), .supervisory_low(slow),
        .battery_control_pin(pin), .cell_adc_done(cdone),
        .cell_adc_result(cres), .supervisory_adc_done(sdone),
        .supervisory_adc_result(sres), .supervisory_adc_start(sstart),
        .switched_supply_source(src), .metering_adc_enable(men),
        .power_event_irq(irq)
    );
    bsw_partner PM (
        .clk(clk), .supervisory_adc_start(sstart),
        .main_supply_low(mlow), .supervisory_low(slow),
        .battery_control_pin(pin), .cell_adc_done(cdone),
        .cell_adc_result(cres), .supervisory_adc_done(sdone),
        .supervisory_adc_result(sres)
    );

    // ------------------------------------------------
    // reporting
    // ------------------------------------------------
    task automatic fail(input string msg);
        error_cnt++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask
    task automatic compare_byte(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("byte %h expected %h", g, e));
    endtask
    task automatic compare_bit(input logic g, input logic e);
        samples_checked++;
        if (g !== e) fail($sformatf("bit %b expected %b", g, e));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------
    // register bus and supply stimulus
    // ------------------------------------------------
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        settle(1);
        sfr_wr = 1'b1;
        addr = a;
        wdata = d;
        settle(1);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        settle(1);
        sfr_rd = 1'b1;
        addr = a;
        rd_q.push_back(e);
        settle(1);
        sfr_rd = 1'b0;
    endtask
    task automatic drive(input int w, input logic b);
        settle(1);
        case (w)
            0: PM.main_supply_low = b;
            1: PM.supervisory_low = b;
            default: PM.battery_control_pin = b;
        endcase
    endtask
    // drive one input and wait for the supply to move to s
    task automatic go(input logic s, input int w, input logic b);
        int n;
        src_q.push_back(s);
        drive(w, b);
        n = 0;
        while (src_q.size() != 0 && n < 20) begin
            settle(1);
            n++;
        end
        if (src_q.size() != 0) fail("supply did not move");
    endtask

    // ------------------------------------------------
    // monitors: each result takes the oldest note
    // ------------------------------------------------
    always @(posedge clk) begin
        if (sfr_rd === 1'b1) begin
            if (rd_q.size() == 0) fail("read without note");
            else compare_byte(rdata, rd_q.pop_front());
        end
    end
    always @(posedge clk) begin
        if (rst) last_src <= 1'b1;
        else if (src !== last_src) begin
            last_src <= src;
            if (src_q.size() == 0) fail("unexpected supply move");
            else compare_bit(src, src_q.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        fail("watchdog expired");
        tally_and_finish;
    end

    initial begin
        seed = 32'hbe29;
        rst = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        settle(20);
        rst = 1'b0;
        rd(bsw_pkg::ADDR_PERIPHERAL_CONFIGURATION, 8'h40);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        rd(bsw_pkg::ADDR_IEIP, 8'h00);
        rd(8'h80, 8'h00);
        wr(bsw_pkg::ADDR_EV_EN, 8'h8f);
        wr(bsw_pkg::ADDR_IEIP, 8'h02);
        go(1'b0, 0, 1'b1);
        settle(2);
        compare_bit(men, 1'b0);
        compare_bit(irq, 1'b1);
        rd(bsw_pkg::ADDR_PERIPHERAL_CONFIGURATION, 8'h00);
        wr(bsw_pkg::ADDR_EV_FLAG, 8'hff);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h02);
        wr(bsw_pkg::ADDR_EV_FLAG, 8'hfd);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        settle(2);
        compare_bit(irq, 1'b0);
        go(1'b1, 0, 1'b0);
        settle(2);
        compare_bit(men, 1'b1);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h80);
        wr(bsw_pkg::ADDR_EV_FLAG, 8'h7f);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        wr(bsw_pkg::ADDR_SW_CFG, 8'h01);
        go(1'b0, 1, 1'b1);
        settle(20);
        go(1'b1, 1, 1'b0);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h83);
        wr(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        wr(bsw_pkg::ADDR_SW_CFG, 8'h02);
        wr(bsw_pkg::ADDR_PIN_CFG, 8'h02);
        drive(0, 1'b1);
        drive(2, 1'b0);
        settle(20);
        rd(bsw_pkg::ADDR_PERIPHERAL_CONFIGURATION, 8'h40);
        drive(2, 1'b1);
        drive(0, 1'b0);
        wr(bsw_pkg::ADDR_SW_CFG, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr(bsw_pkg::ADDR_PIN_CFG, i ? 8'h0a : 8'h02);
            go(1'b0, 2, 1'b0);
            settle(10);
            go(1'b1, 2, 1'b1);
        end
        wr(bsw_pkg::ADDR_PIN_CFG, 8'h00);
        drive(2, 1'b0);
        settle(10);
        drive(2, 1'b1);
        wr(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        wr(bsw_pkg::ADDR_EV_EN, 8'h01);
        wr(bsw_pkg::ADDR_IEIP, 8'h00);
        drive(1, 1'b1);
        settle(6);
        drive(1, 1'b0);
        settle(4);
        compare_bit(irq, 1'b0);
        wr(bsw_pkg::ADDR_IEIP, 8'h02);
        settle(2);
        compare_bit(irq, 1'b1);
        wr(bsw_pkg::ADDR_EV_EN, 8'h00);
        settle(2);
        compare_bit(irq, 1'b0);
        wr(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        wr(bsw_pkg::ADDR_DELTA, 8'h10);
        PM.sup_level = 8'h11;
        n0 = PM.start_cnt;
        wr(bsw_pkg::ADDR_ADC_GO, 8'h01);
        settle(12);
        compare_bit(PM.start_cnt == n0 + 1, 1'b1);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h08);
        wr(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        PM.sup_level = 8'h21;
        wr(bsw_pkg::ADDR_ADC_GO, 8'h01);
        settle(12);
        rd(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        rd(bsw_pkg::ADDR_ADC_GO, 8'h00);
        n0 = PM.start_cnt;
        settle(4200);
        compare_bit(PM.start_cnt > n0, 1'b1);
        for (i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            PM.cell_conv(v);
            settle(6);
            rd(bsw_pkg::ADDR_BAT_ADC, v);
            rd(bsw_pkg::ADDR_EV_FLAG, 8'h04);
            wr(bsw_pkg::ADDR_EV_FLAG, 8'h00);
        end
        tally_and_finish;
    end
endmodule
